// ===== inc/sar_adc_map.vh
`ifndef SAR_ADC_MAP_VH
`define SAR_ADC_MAP_VH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define ADDR_CTRL 3'h0
`define ADDR_SETUP 3'h1
`define ADDR_RES_HI 3'h2
`define ADDR_RES_LO 3'h3
`define ADDR_FLAGS 3'h4
// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define CTRL_EN_BIT 0
`define CTRL_GO_BIT 1
`define CTRL_RESET 8'h00
`define SETUP_RESET 8'h00
`define FLAG_DONE_BIT 0
`define FLAG_IRQEN_BIT 1
`define CHAN_LAST_PIN 5'h0B
`define CHAN_DAC 5'h1D
`define CHAN_FVR 5'h1F
`define SEL_NONE 4'hF
`define SEL_DAC 4'hC
`define SEL_FVR 4'hD
// ----------------------------------------
// timing
// ----------------------------------------
`define RESULT_BITS 10
`define TAD_HALF_STEPS 23
`define RC_START_DELAY 4
`endif

// ===== rtl/sar_adc_sequencer.v
// Chosen here: the strobed register port and the register offsets.
`timescale 1ns/100ps
`include "sar_adc_map.vh"
// Notes on behaviour
// - converts selected input by successive approximation into ten result bits
// - channel field picks pins 0-11, dac, fixed reference, or nothing
// - three-bit clock select: six divided rates or the rc clock
// - a conversion takes eleven and a half bit periods
// - completion flag sets at every normal end regardless of interrupt enable
// - enabled completion during sleep raises wake
// - enable bit powers the converter
// - writing go starts; go reads one while busy
// - normal end clears go, sets flag, loads result
// - clearing go aborts; unresolved bits copy last decided bit
// - reset clears registers and stops any conversion
// - rc clock delays start until the second instruction tick
// - only the rc clock keeps converting in sleep
// - sleep, rc, no interrupt: power down after end, enable kept
// - sleep on divided clock aborts and powers down, enable kept
// - special event trigger sets go and resets the timer
// - three positive and two negative reference sources
// - positive 00 supply, 10 pin, 11 fixed; negative bit picks pin
// - result left or right justified by justify bit
// - justify one zeroes top six high bits, zero zeroes low six
module sar_adc_sequencer
(
   input wire i_ref_clk,
   input wire i_srst,
   input wire [2:0] i_addr,
   input wire [7:0] i_wdata,
   input wire i_wr,
   input wire i_rd,
   output reg [7:0] o_rdata,
   input wire i_sleep,
   input wire i_rc_tick,
   input wire i_instr_tick,
   input wire i_event_trig,
   input wire i_comp_out,
   output reg [9:0] o_dac_trial,
   output reg [3:0] o_chan_route,
   output reg [1:0] o_pos_ref,
   output reg o_neg_ref_pin,
   output reg o_analog_on,
   output reg o_hold_open,
   output reg o_wake,
   output reg o_timer_clear
);
   // ----------------------------------------
   // registers and state
   // ----------------------------------------
   localparam ST_IDLE = 2'd0;
   localparam ST_WAIT = 2'd1;
   localparam ST_CONV = 2'd2;
   reg [1:0] state;
   reg [7:0] ctrl;
   reg [7:0] setup;
   reg [9:0] result;
   reg [9:0] trial;
   reg [3:0] bit_idx;
   reg [4:0] half_cnt;
   reg [2:0] rc_wait;
   reg [5:0] div_cnt;
   reg done_flag;
   reg irq_en;
   reg pwr_down;
   reg sleep_q1;
   reg sleep_q2;
   reg rc_q1;
   reg rc_q2;
   reg rc_q3;
   reg trig_q1;
   reg trig_q2;
   reg trig_q3;
   wire use_rc = (setup[5:4] == 2'b11);
   wire [2:0] clk_sel = setup[6:4];
   wire sleep_now = sleep_q2;
   wire rc_edge = rc_q2 & ~rc_q3;
   wire trig_edge = trig_q2 & ~trig_q3;
   wire wr_ctrl = i_wr && (i_addr == `ADDR_CTRL);
   // go only sticks when the converter was already on and stays on
   wire go_write = i_wdata[`CTRL_GO_BIT] & i_wdata[`CTRL_EN_BIT] & ctrl[`CTRL_EN_BIT];
   reg half_tick;
   reg [5:0] div_top;
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   // unresolved bits copy the last decided bit
   function [9:0] fill_partial;
      input [9:0] val;
      input [3:0] idx;
      integer k;
      reg last;
      begin
         last = (idx == 4'd9) ? 1'b0 : val[idx + 1];
         fill_partial = val;
         for (k = 0; k < 10; k = k + 1)
            if (k <= idx)
               fill_partial[k] = last;
      end
   endfunction
   // ----------------------------------------
   // input sync and bit clock
   // ----------------------------------------
   always @(posedge i_ref_clk)
   begin
      sleep_q1 <= i_sleep;
      sleep_q2 <= sleep_q1;
      rc_q1 <= i_rc_tick;
      rc_q2 <= rc_q1;
      rc_q3 <= rc_q2;
      trig_q1 <= i_event_trig;
      trig_q2 <= trig_q1;
      trig_q3 <= trig_q2;
   end
   // half bit periods; divided rates count system clocks
   always @*
   begin
      case (clk_sel)
         3'b000: div_top = 6'd0;
         3'b100: div_top = 6'd1;
         3'b001: div_top = 6'd3;
         3'b101: div_top = 6'd7;
         3'b010: div_top = 6'd15;
         3'b110: div_top = 6'd31;
         default: div_top = 6'd0;
      endcase
      half_tick = use_rc ? rc_edge : (div_cnt == div_top);
   end
   always @(posedge i_ref_clk)
   begin
      if (i_srst || state != ST_CONV || half_tick)
         div_cnt <= 6'd0;
      else
         div_cnt <= div_cnt + 6'd1;
   end
   // ----------------------------------------
   // sequencer
   // ----------------------------------------
   always @(posedge i_ref_clk)
   begin
      o_timer_clear <= 1'b0;
      o_wake <= 1'b0;
      if (i_srst)
      begin
         state <= ST_IDLE;
         ctrl <= `CTRL_RESET;
         setup <= `SETUP_RESET;
         result <= 10'h000;
         trial <= 10'h000;
         bit_idx <= 4'd9;
         half_cnt <= 5'd0;
         rc_wait <= 3'd0;
         done_flag <= 1'b0;
         irq_en <= 1'b0;
         pwr_down <= 1'b0;
      end
      else
      begin
         if (i_wr && i_addr == `ADDR_SETUP)
            setup <= {i_wdata[7:4], 1'b0, i_wdata[2:0]};
         if (i_wr && i_addr == `ADDR_FLAGS)
         begin
            irq_en <= i_wdata[`FLAG_IRQEN_BIT];
            if (!i_wdata[`FLAG_DONE_BIT])
               done_flag <= 1'b0;
         end
         if (wr_ctrl)
         begin
            ctrl <= {1'b0, i_wdata[6:2], go_write, i_wdata[`CTRL_EN_BIT]};
            if (!i_wdata[`CTRL_EN_BIT])
               pwr_down <= 1'b0;
         end
         if (!sleep_now)
            pwr_down <= 1'b0;
         if (trig_edge && ctrl[`CTRL_EN_BIT])
         begin
            ctrl[`CTRL_GO_BIT] <= 1'b1;
            o_timer_clear <= 1'b1;
         end
         case (state)
            ST_IDLE:
            begin
               if ((wr_ctrl && go_write) ||
                   (trig_edge && ctrl[`CTRL_EN_BIT]))
               begin
                  rc_wait <= 3'd0;
                  state <= use_rc ? ST_WAIT : ST_CONV;
                  trial <= 10'h200;
                  bit_idx <= 4'd9;
                  half_cnt <= 5'd0;
               end
            end
            ST_WAIT:
            begin
               if (i_instr_tick)
                  rc_wait <= rc_wait + 3'd1;
               if (i_instr_tick && rc_wait == 3'd1)
                  state <= ST_CONV;
            end
            ST_CONV:
            begin
               if (half_tick)
               begin
                  half_cnt <= half_cnt + 5'd1;
                  // decide on the second half of each bit period
                  if (half_cnt[0] && half_cnt >= 5'd3 && half_cnt <= 5'd21)
                  begin
                     // comparator shares our clock; a sync stage would miss the /2 rate
                     trial[bit_idx] <= i_comp_out;
                     if (bit_idx != 4'd0)
                     begin
                        trial[bit_idx - 4'd1] <= 1'b1;
                        bit_idx <= bit_idx - 4'd1;
                     end
                  end
                  if (half_cnt == `TAD_HALF_STEPS - 1)
                  begin
                     result <= trial;
                     ctrl[`CTRL_GO_BIT] <= 1'b0;
                     done_flag <= 1'b1;
                     if (sleep_now && irq_en)
                        o_wake <= 1'b1;
                     if (sleep_now && !irq_en)
                        pwr_down <= 1'b1;
                     state <= ST_IDLE;
                  end
               end
            end
            default: state <= ST_IDLE;
         endcase
         if (state != ST_IDLE)
         begin
            if (wr_ctrl && !i_wdata[`CTRL_GO_BIT])
            begin
               result <= fill_partial(trial, bit_idx);
               state <= ST_IDLE;
            end
            else if (sleep_now && !use_rc)
            begin
               ctrl[`CTRL_GO_BIT] <= 1'b0;
               pwr_down <= 1'b1;
               state <= ST_IDLE;
            end
            if (wr_ctrl && !i_wdata[`CTRL_EN_BIT])
               state <= ST_IDLE;
         end
      end
   end
   // ----------------------------------------
   // analog side outputs
   // ----------------------------------------
   always @(posedge i_ref_clk)
   begin
      if (i_srst)
      begin
         o_dac_trial <= 10'h000;
         o_chan_route <= `SEL_NONE;
         o_pos_ref <= 2'b00;
         o_neg_ref_pin <= 1'b0;
         o_analog_on <= 1'b0;
         o_hold_open <= 1'b0;
      end
      else
      begin
         o_dac_trial <= trial;
         if (ctrl[6:2] <= `CHAN_LAST_PIN)
            o_chan_route <= ctrl[5:2];
         else if (ctrl[6:2] == `CHAN_DAC)
            o_chan_route <= `SEL_DAC;
         else if (ctrl[6:2] == `CHAN_FVR)
            o_chan_route <= `SEL_FVR;
         else
            o_chan_route <= `SEL_NONE;
         o_pos_ref <= setup[1:0];
         o_neg_ref_pin <= setup[2];
         o_analog_on <= ctrl[`CTRL_EN_BIT] & ~pwr_down;
         o_hold_open <= (state == ST_CONV);
      end
   end
   // ----------------------------------------
   // read port
   // ----------------------------------------
   always @(posedge i_ref_clk)
   begin
      if (i_srst)
         o_rdata <= 8'h00;
      else if (i_rd)
      begin
         case (i_addr)
            `ADDR_CTRL: o_rdata <= ctrl;
            `ADDR_SETUP: o_rdata <= setup;
            `ADDR_RES_HI: o_rdata <= setup[7] ? {6'h00, result[9:8]} : result[9:2];
            `ADDR_RES_LO: o_rdata <= setup[7] ? result[7:0] : {result[1:0], 6'h00};
            `ADDR_FLAGS: o_rdata <= {6'h00, irq_en, done_flag};
            default: o_rdata <= 8'h00;
         endcase
      end
      else
         o_rdata <= 8'h00;
   end
endmodule // sar_adc_sequencer

// ===== test/sar_adc_props.sv
`timescale 1ns/100ps
// ------------------------
// port checks
// ------------------------
module sar_adc_props
(
   input wire i_ref_clk,
   input wire i_srst,
   input wire i_rd,
   input wire i_sleep,
   input wire i_event_trig,
   input wire [7:0] o_rdata,
   input wire [9:0] o_dac_trial,
   input wire [3:0] o_chan_route,
   input wire o_analog_on,
   input wire o_hold_open,
   input wire o_wake,
   input wire o_timer_clear
);
   default clocking @(posedge i_ref_clk);
   endclocking
   default disable iff (i_srst);
   chk_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
      else $error("read data outside its slot");
   chk_reset_state: assert property ($fell(i_srst) |-> o_chan_route == 4'hF && !o_hold_open)
      else $error("state after reset");
   chk_route_code: assert property (o_chan_route != 4'hE)
      else $error("unused route code");
   chk_wake_pulse: assert property (o_wake |=> !o_wake)
      else $error("wake longer than a cycle");
   chk_wake_sleep: assert property (o_wake |-> $past(i_sleep, 3))
      else $error("wake without sleep");
   chk_timer_pulse: assert property (o_timer_clear |=> !o_timer_clear)
      else $error("timer clear too long");
   chk_timer_cause: assert property ($rose(i_event_trig) |-> ##[1:6] o_timer_clear)
      else $error("trigger gave no timer clear");
   chk_hold_power: assert property ($rose(o_hold_open) |-> o_analog_on)
      else $error("conversion while powered down");
   chk_trial_msb: assert property ($rose(o_hold_open) |-> ##[0:40] o_dac_trial == 10'h200)
      else $error("first trial not msb");
endmodule // sar_adc_props

// ===== test/sar_comp_model.sv
`timescale 1ns/100ps
// ------------------------
// comparator core
// ------------------------
module sar_comp_model
(
   input wire i_ref_clk,
   input wire [9:0] i_level,
   input wire [9:0] i_trial,
   output reg o_comp
);
   // the comparator settles within the cycle that the trial word stands
   always @*
   begin
      o_comp = (i_level >= i_trial);
   end
endmodule // sar_comp_model

// ===== test/sar_adc_sequencer_tb.sv
`timescale 1ns/100ps
module sar_adc_sequencer_tb;
   reg i_ref_clk = 1'h0, i_srst = 1'h1, i_wr = 1'h0, i_rd = 1'h0, i_sleep = 1'h0;
   reg i_rc_tick = 1'h0, i_instr_tick = 1'h0, i_event_trig = 1'h0, rc_run = 1'h0;
   reg [2:0] i_addr = 3'h0;
   reg [7:0] i_wdata = 8'h00, q;
   reg [9:0] level = 10'h2A5;
   reg [31:0] cyc = 32'h0;
   wire [7:0] o_rdata;
   wire [9:0] o_dac_trial;
   wire [3:0] o_chan_route;
   wire [1:0] o_pos_ref;
   wire o_neg_ref_pin, o_analog_on, o_hold_open, o_wake, o_timer_clear, comp;
   integer n_errors = 0, check_count = 0, n, k, t;
   sar_adc_sequencer dut (.i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_sleep(i_sleep),
      .i_rc_tick(i_rc_tick), .i_instr_tick(i_instr_tick), .i_event_trig(i_event_trig),
      .i_comp_out(comp), .o_dac_trial(o_dac_trial), .o_chan_route(o_chan_route),
      .o_pos_ref(o_pos_ref), .o_neg_ref_pin(o_neg_ref_pin), .o_analog_on(o_analog_on),
      .o_hold_open(o_hold_open), .o_wake(o_wake), .o_timer_clear(o_timer_clear));
   sar_comp_model core (.i_ref_clk(i_ref_clk), .i_level(level), .i_trial(o_dac_trial),
      .o_comp(comp));
   // ------------------------
   // clocks and bus tasks
   // ------------------------
   initial forever #20 i_ref_clk = ~i_ref_clk;
   always @(posedge i_ref_clk)
   begin
      cyc <= cyc + 1;
      i_instr_tick <= cyc[1:0] == 2'h3;
      if (rc_run && cyc % 3 == 0)
         i_rc_tick <= ~i_rc_tick;
   end
   task chk(input [7:0] got, input [7:0] e);
   begin
      check_count = check_count + 1;
      if (got !== e)
      begin
         n_errors = n_errors + 1;
         $display("Error %0t: got %h want %h", $time, got, e);
      end
   end
   endtask
   task wr(input [2:0] a, input [7:0] d);
   begin
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'h1;
      @(posedge i_ref_clk);
      i_wr <= 1'h0;
      @(posedge i_ref_clk);
   end
   endtask
   task rd(input [2:0] a);
   begin
      i_addr <= a;
      i_rd <= 1'h1;
      @(posedge i_ref_clk);
      i_rd <= 1'h0;
      #1 q = o_rdata;
      @(posedge i_ref_clk);
   end
   endtask
   task rdc(input [2:0] a, input [7:0] e);
   begin
      rd(a);
      chk(q, e);
   end
   endtask
   // poll go; n counts clocks, bounded
   task poll;
   begin
      n = 0;
      q = 8'h02;
      while (q[1] && n < 3000)
      begin
         rd(3'h0);
         n = n + 2;
      end
   end
   endtask
   task end_sim;
   begin
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   end
   endtask
   initial
   begin
      #800000;
      n_errors = n_errors + 1;
      end_sim;
   end
   initial
   begin
      repeat (16) @(posedge i_ref_clk);
      i_srst <= 1'h0;
      @(posedge i_ref_clk);
      for (k = 0; k < 8; k = k + 1)
         rdc(k[2:0], 8'h00);
      $display("reset values end");
      wr(3'h0, 8'h01);
      for (k = 0; k < 6; k = k + 1)
      begin
         wr(3'h1, {1'h1, k[0], k[2:1], 4'h0});
         wr(3'h0, 8'h03);
         poll;
         t = 23 << k;
         chk({7'h00, n >= t - 2 && n <= t + 12}, 8'h01);
         rdc(3'h2, 8'h02);
         rdc(3'h3, 8'hA5);
         rdc(3'h4, 8'h01);
         wr(3'h4, 8'h00);
      end
      rdc(3'h4, 8'h00);
      wr(3'h1, 8'h00);
      wr(3'h0, 8'h03);
      poll;
      rdc(3'h2, 8'hA9);
      rdc(3'h3, 8'h40);
      $display("clock and format end");
      level = 10'h300;
      wr(3'h1, 8'h80);
      wr(3'h0, 8'h03);
      repeat (14) @(posedge i_ref_clk);
      wr(3'h0, 8'h01);
      rdc(3'h0, 8'h01);
      rdc(3'h2, 8'h03);
      rdc(3'h3, 8'h00);
      wr(3'h0, 8'h00);
      wr(3'h0, 8'h02);
      rdc(3'h0, 8'h00);
      #1 chk({7'h00, o_analog_on}, 8'h00);
      $display("abort and refuse end");
      for (k = 0; k < 32; k = k + 1)
      begin
         wr(3'h0, {1'h0, k[4:0], 2'h1});
         t = k < 12 ? k : k == 29 ? 12 : k == 31 ? 13 : 15;
         #41 chk({4'h0, o_chan_route}, t[7:0]);
      end
      wr(3'h1, 8'h86);
      #41 chk({5'h00, o_neg_ref_pin, o_pos_ref}, 8'h06);
      wr(3'h1, 8'h83);
      #41 chk({5'h00, o_neg_ref_pin, o_pos_ref}, 8'h03);
      $display("routing end");
      level = 10'h2A5;
      wr(3'h0, 8'h01);
      wr(3'h1, 8'hE0);
      wr(3'h0, 8'h03);
      i_sleep <= 1'h1;
      repeat (8) @(posedge i_ref_clk);
      #1 chk({7'h00, o_analog_on}, 8'h00);
      rdc(3'h0, 8'h01);
      i_sleep <= 1'h0;
      wr(3'h4, 8'h02);
      wr(3'h1, 8'hB0);
      rc_run = 1'h1;
      wr(3'h0, 8'h03);
      i_sleep <= 1'h1;
      n = 0;
      #1;
      while (o_wake !== 1'h1 && n < 2000)
      begin
         #40 n = n + 1;
      end
      chk({7'h00, n > 69 && n < 2000}, 8'h01);
      rdc(3'h4, 8'h03);
      wr(3'h4, 8'h00);
      wr(3'h0, 8'h03);
      poll;
      #41 chk({7'h00, o_analog_on}, 8'h00);
      rdc(3'h0, 8'h01);
      i_sleep <= 1'h0;
      rc_run = 1'h0;
      $display("sleep end");
      wr(3'h1, 8'h80);
      i_event_trig <= 1'h1;
      repeat (6) @(posedge i_ref_clk);
      i_event_trig <= 1'h0;
      rdc(3'h0, 8'h03);
      poll;
      rdc(3'h4, 8'h01);
      wr(3'h0, 8'h03);
      i_srst <= 1'h1;
      @(posedge i_ref_clk);
      i_srst <= 1'h0;
      @(posedge i_ref_clk);
      rdc(3'h0, 8'h00);
      rdc(3'h4, 8'h00);
      $display("trigger and reset end");
      end_sim;
   end
endmodule // sar_adc_sequencer_tb
bind sar_adc_sequencer sar_adc_props chk (.i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_rd(i_rd),
   .i_sleep(i_sleep), .i_event_trig(i_event_trig), .o_rdata(o_rdata),
   .o_dac_trial(o_dac_trial), .o_chan_route(o_chan_route), .o_analog_on(o_analog_on),
   .o_hold_open(o_hold_open), .o_wake(o_wake), .o_timer_clear(o_timer_clear));
